// ===== hdl/acps_pkg.sv
// Constants and types for the audio codec power-up sequencer
package acps_pkg;
    localparam int ACPS_BLOCKS = 7;
    localparam int ACPS_IDX_W = 6;
    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [5:0] ACPS_IDX_POWER = 6'h00;
    localparam logic [5:0] ACPS_IDX_AUX = 6'h01;
    localparam logic [5:0] ACPS_IDX_PRECH = 6'h0C;
    localparam logic [5:0] ACPS_IDX_RESET = 6'h10;
    localparam logic [5:0] ACPS_IDX_AMP = 6'h11;
    localparam logic [5:0] ACPS_IDX_CHARGING = 6'h14;
    localparam logic [5:0] ACPS_IDX_READY = 6'h15;
    // ==========================================================
    // Reset values
    localparam logic [7:0] ACPS_RST_POWER = 8'h00;
    localparam logic [7:0] ACPS_RST_AUX = 8'h00;
    localparam logic [7:0] ACPS_RST_PRECH = 8'h00;
    localparam logic [2:0] ACPS_RST_RESET = 3'h0;
    localparam logic [6:0] ACPS_RST_AMP = 7'h00;
    // ==========================================================
    // Field positions
    localparam int ACPS_POW_LEFT_IN = 0;
    localparam int ACPS_POW_RIGHT_IN = 1;
    localparam int ACPS_POW_RIGHT_CONV = 2;
    localparam int ACPS_POW_LEFT_CONV = 3;
    localparam int ACPS_POW_LEFT_OUT = 4;
    localparam int ACPS_POW_RIGHT_OUT = 5;
    localparam int ACPS_POW_AUX_IN = 6;
    localparam int ACPS_POW_DRIVER = 7;
    localparam int ACPS_PRECH_MASTER_ON = 0;
    localparam int ACPS_PRECH_FC_LSB = 1;
    localparam int ACPS_RSTREG_CODEC = 0;
    localparam int ACPS_RSTREG_FILTER = 1;
    localparam int ACPS_RSTREG_MASK = 2;
    localparam int ACPS_AMP_ON = 6;
    localparam int ACPS_AMP_CHARGE = 5;
    localparam int ACPS_AMP_LEVEL = 4;
    localparam int ACPS_AMP_GAIN_MSB = 3;
    // ==========================================================
    // Gain mapping in dB
    localparam logic signed [5:0] ACPS_GAIN_MAX_DB = 6'sh14;
    localparam logic signed [5:0] ACPS_GAIN_STEP_DB = 6'sh03;
    localparam logic signed [5:0] ACPS_GAIN_MIN_DB = -6'sh16;
    localparam logic [3:0] ACPS_GAIN_CODE_ZERO = 4'h0;
    localparam logic [3:0] ACPS_GAIN_CODE_ONE = 4'h1;

    typedef enum logic [1:0] {
        ACPS_BLK_OFF,
        ACPS_BLK_CHARGING,
        ACPS_BLK_READY
    } acps_blk_state_t;

    typedef enum logic [1:0] {
        ACPS_AMP_STANDBY,
        ACPS_AMP_CAP_CHARGE,
        ACPS_AMP_ACTIVE,
        ACPS_AMP_FORBIDDEN
    } acps_amp_mode_t;
endpackage

// ===== hdl/acps_block_if.sv
// Power and fastcharge bundle between register file and block tracker
interface acps_block_if #(
    parameter int N = 7
);
    logic [N-1:0] power;
    logic [N-1:0] fastcharge;
    logic [N-1:0] charging;
    logic [N-1:0] ready;

    modport regs (output power, output fastcharge, input charging, input ready);
    modport tracker (input power, input fastcharge, output charging, output ready);
endinterface

// ===== hdl/acps_fastcharge.sv
// Per-block fastcharge and power-up tracker
module acps_fastcharge #(
    parameter int N = 7
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    acps_block_if.tracker blk
);
    // ==========================================================
    // One independent tracker per block
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_blk
            acps_pkg::acps_blk_state_t state;

            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    state <= acps_pkg::ACPS_BLK_OFF;
                else if (ce)
                begin
                    if (!blk.power[i])
                        state <= acps_pkg::ACPS_BLK_OFF;
                    else
                    begin
                        case (state)
                            acps_pkg::ACPS_BLK_OFF:
                                // Power without fastcharge skips the charge
                                state <= blk.fastcharge[i] ? acps_pkg::ACPS_BLK_CHARGING
                                                          : acps_pkg::ACPS_BLK_READY;
                            acps_pkg::ACPS_BLK_CHARGING:
                                if (!blk.fastcharge[i])
                                    state <= acps_pkg::ACPS_BLK_READY;
                            default:
                                state <= state;
                        endcase
                    end
                end
            end

            // Each block has its own state, so all may charge at once
            assign blk.charging[i] = (state == acps_pkg::ACPS_BLK_CHARGING);
            assign blk.ready[i] = (state == acps_pkg::ACPS_BLK_READY);

            chk_charge_start: assert property (@(posedge clk) disable iff (!rst_b)
                (ce && blk.power[i] && blk.fastcharge[i] && state == acps_pkg::ACPS_BLK_OFF)
                |=> blk.charging[i])
                else $error("fastcharge did not start on power");
            chk_power_drop: assert property (@(posedge clk) disable iff (!rst_b)
                (ce && !blk.power[i]) |=> !blk.charging[i] && !blk.ready[i])
                else $error("block stayed up after power cleared");
            chk_charge_end: assert property (@(posedge clk) disable iff (!rst_b)
                (ce && blk.charging[i] && blk.power[i] && !blk.fastcharge[i])
                |=> blk.ready[i])
                else $error("block not ready after fastcharge cleared");
            chk_ready_hold: assert property (@(posedge clk) disable iff (!rst_b)
                (blk.ready[i] && blk.power[i]) |=> !blk.charging[i])
                else $error("ready block recharged without power cycle");
        end
    endgenerate
endmodule // acps_fastcharge

// ===== hdl/acps_top.sv
// Audio codec power control registers, amplifier control and block trackers
//
// Register access over Avalon-MM is this design's own decision.
module acps_top #(
    parameter int N = acps_pkg::ACPS_BLOCKS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic audioReset_b,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [N-1:0] blockPower,
    output logic [N-1:0] blockCharging,
    output logic [N-1:0] blockReady,
    output logic leftConverterPower,
    output logic rightConverterPower,
    output logic codecReset_b,
    output logic filterReset_b,
    output logic codecResetMask,
    output logic ampOn,
    output logic ampCapCharge,
    output logic ampPowerLevel,
    output logic [3:0] ampGainCode,
    output logic signed [5:0] ampGainDb,
    output logic ampModeError
);
    // ==========================================================
    // Bus slave: one wait state on every access
    logic served;
    logic [5:0] index;
    logic request;
    logic wrEn;
    logic [7:0] powerReg;
    logic [7:0] auxReg;
    logic [7:0] prechReg;
    logic [2:0] resetReg;
    logic [6:0] ampReg;
    logic [7:0] next_readByte;
    acps_pkg::acps_amp_mode_t ampMode;
    acps_block_if #(.N(N)) blk ();

    assign index = address[7:2];
    assign request = read || write;
    // Write lands at the edge where waitrequest is low
    assign wrEn = write && served && byteenable[0] && ce;
    assign waitrequest = request && !served;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            served <= 1'b0;
        else if (ce)
            served <= request && !served;
    end

    always_comb
    begin
        next_readByte = 8'h00;
        if (index == acps_pkg::ACPS_IDX_POWER)
            next_readByte = powerReg;
        else if (index == acps_pkg::ACPS_IDX_AUX)
            next_readByte = auxReg;
        else if (index == acps_pkg::ACPS_IDX_PRECH)
            next_readByte = prechReg;
        else if (index == acps_pkg::ACPS_IDX_RESET)
            next_readByte = {5'h00, resetReg};
        else if (index == acps_pkg::ACPS_IDX_AMP)
            next_readByte = {1'b0, ampReg};
        else if (index == acps_pkg::ACPS_IDX_CHARGING)
            next_readByte = 8'(blk.charging);
        else if (index == acps_pkg::ACPS_IDX_READY)
            next_readByte = 8'(blk.ready);
    end

    // Read data captured during the wait state, stable at release
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            readdata <= 32'h00000000;
        else if (ce && read && !served)
            readdata <= {24'h000000, next_readByte};
    end

    // ==========================================================
    // Codec registers; the audio reset pin clears them all, but only in cycles where ce is high
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            powerReg <= acps_pkg::ACPS_RST_POWER;
        else if (ce)
        begin
            if (!audioReset_b)
                powerReg <= acps_pkg::ACPS_RST_POWER;
            else if (wrEn && index == acps_pkg::ACPS_IDX_POWER)
                powerReg <= writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            auxReg <= acps_pkg::ACPS_RST_AUX;
        else if (ce)
        begin
            if (!audioReset_b)
                auxReg <= acps_pkg::ACPS_RST_AUX;
            else if (wrEn && index == acps_pkg::ACPS_IDX_AUX)
                auxReg <= writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            prechReg <= acps_pkg::ACPS_RST_PRECH;
        else if (ce)
        begin
            if (!audioReset_b)
                prechReg <= acps_pkg::ACPS_RST_PRECH;
            else if (wrEn && index == acps_pkg::ACPS_IDX_PRECH)
                prechReg <= writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            resetReg <= acps_pkg::ACPS_RST_RESET;
        else if (ce)
        begin
            if (!audioReset_b)
                resetReg <= acps_pkg::ACPS_RST_RESET;
            else if (wrEn && index == acps_pkg::ACPS_IDX_RESET)
                resetReg <= writedata[2:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ampReg <= acps_pkg::ACPS_RST_AMP;
        else if (ce)
        begin
            if (!audioReset_b)
                ampReg <= acps_pkg::ACPS_RST_AMP;
            else if (wrEn && index == acps_pkg::ACPS_IDX_AMP)
                ampReg <= writedata[6:0];
        end
    end

    // ==========================================================
    // Block power pairs: master, line ins, line outs, aux, driver
    assign blk.power = {powerReg[acps_pkg::ACPS_POW_DRIVER],
                        powerReg[acps_pkg::ACPS_POW_AUX_IN],
                        powerReg[acps_pkg::ACPS_POW_RIGHT_OUT],
                        powerReg[acps_pkg::ACPS_POW_LEFT_OUT],
                        powerReg[acps_pkg::ACPS_POW_RIGHT_IN],
                        powerReg[acps_pkg::ACPS_POW_LEFT_IN],
                        prechReg[acps_pkg::ACPS_PRECH_MASTER_ON]};
    assign blk.fastcharge = prechReg[acps_pkg::ACPS_PRECH_FC_LSB +: N];

    acps_fastcharge #(.N(N)) u_fastcharge (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .blk(blk)
    );

    assign blockPower = blk.power;
    assign blockCharging = blk.charging;
    assign blockReady = blk.ready;
    // Converters have no fastcharge phase
    assign leftConverterPower = powerReg[acps_pkg::ACPS_POW_LEFT_CONV];
    assign rightConverterPower = powerReg[acps_pkg::ACPS_POW_RIGHT_CONV];
    assign codecReset_b = resetReg[acps_pkg::ACPS_RSTREG_CODEC];
    assign filterReset_b = resetReg[acps_pkg::ACPS_RSTREG_FILTER];
    assign codecResetMask = resetReg[acps_pkg::ACPS_RSTREG_MASK];

    // ==========================================================
    // Amplifier mode, level and gain
    always_comb
    begin
        case ({ampReg[acps_pkg::ACPS_AMP_ON], ampReg[acps_pkg::ACPS_AMP_CHARGE]})
            2'b00: ampMode = acps_pkg::ACPS_AMP_STANDBY;
            2'b01: ampMode = acps_pkg::ACPS_AMP_CAP_CHARGE;
            2'b10: ampMode = acps_pkg::ACPS_AMP_ACTIVE;
            default: ampMode = acps_pkg::ACPS_AMP_FORBIDDEN;
        endcase
    end

    // Forbidden combination parks the amplifier in standby, avoiding a click
    assign ampOn = (ampMode == acps_pkg::ACPS_AMP_ACTIVE);
    assign ampCapCharge = (ampMode == acps_pkg::ACPS_AMP_CAP_CHARGE);
    assign ampModeError = (ampMode == acps_pkg::ACPS_AMP_FORBIDDEN);
    assign ampPowerLevel = ampReg[acps_pkg::ACPS_AMP_LEVEL];
    assign ampGainCode = ampReg[acps_pkg::ACPS_AMP_GAIN_MSB:0];

    always_comb
    begin
        if (ampGainCode == acps_pkg::ACPS_GAIN_CODE_ZERO)
            ampGainDb = acps_pkg::ACPS_GAIN_MIN_DB;
        else
            ampGainDb = 6'(acps_pkg::ACPS_GAIN_MAX_DB - 6'(acps_pkg::ACPS_GAIN_STEP_DB
                        * $signed({2'h0, ampGainCode - acps_pkg::ACPS_GAIN_CODE_ONE})));
    end

    // ==========================================================
    // Checks
    chk_bus_one_wait: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && request && waitrequest) |=> !waitrequest)
        else $error("access not answered after one wait state");

    chk_amp_write: assert property (@(posedge clk) disable iff (!rst_b)
        (wrEn && audioReset_b && index == acps_pkg::ACPS_IDX_AMP)
        |=> ampGainCode == $past(writedata[3:0]) && ampPowerLevel == $past(writedata[4]))
        else $error("amplifier register write not applied");

    chk_gain_top: assert property (@(posedge clk) disable iff (!rst_b)
        (ampGainCode == acps_pkg::ACPS_GAIN_CODE_ONE) |-> ampGainDb == 6'sh14)
        else $error("gain code one is not +20 dB");

    chk_gain_bottom: assert property (@(posedge clk) disable iff (!rst_b)
        (ampGainCode == 4'hF || ampGainCode == 4'h0) |-> ampGainDb == -6'sh16)
        else $error("lowest gain code is not -22 dB");

    chk_gain_step: assert property (@(posedge clk) disable iff (!rst_b)
        (ampGainCode > 4'h1 && $stable(ampReg) == 1'b0 && ampGainCode == $past(ampGainCode) + 4'h1
         && $past(ampGainCode) != 4'h0) |-> ampGainDb == $past(ampGainDb) - 6'sh03)
        else $error("gain step is not 3 dB");

    chk_amp_mode: assert property (@(posedge clk) disable iff (!rst_b)
        !(ampOn && ampCapCharge) && (ampModeError == (ampReg[6] && ampReg[5])))
        else $error("amplifier mode decode wrong");

    chk_pin_clear: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && !audioReset_b) |=> blockPower == '0 && !codecReset_b && !ampOn)
        else $error("audio reset pin did not clear codec state");

    chk_reset_write: assert property (@(posedge clk) disable iff (!rst_b)
        (wrEn && audioReset_b && index == acps_pkg::ACPS_IDX_RESET)
        |=> codecReset_b == $past(writedata[0]) && codecResetMask == $past(writedata[2]))
        else $error("reset register write not applied");

    chk_read_data: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && read && !served && index == acps_pkg::ACPS_IDX_READY)
        |=> readdata == {24'h000000, 8'($past(blk.ready))})
        else $error("ready status read wrong");

    // ==========================================================
    // Freeze, lane, mapping and pin checks
    chk_wait_idle: assert property (@(posedge clk) disable iff (!rst_b)
        !request |-> !waitrequest)
        else $error("wait state shown with no request");

    chk_read_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && (!read || served)) |=> $stable(readdata))
        else $error("read data changed outside a read");

    chk_charge_read: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && read && !served && index == acps_pkg::ACPS_IDX_CHARGING)
        |=> readdata == {24'h000000, 8'($past(blk.charging))})
        else $error("charging status read wrong");

    chk_ce_freeze: assert property (@(posedge clk) disable iff (!rst_b)
        !ce |=> $stable(powerReg) && $stable(prechReg) && $stable(ampReg) && $stable(blockReady))
        else $error("state moved while clock enable low");

    chk_lane_ignore: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && write && !byteenable[0] && audioReset_b) |=> $stable(ampReg) && $stable(powerReg))
        else $error("write without lane zero changed a register");

    chk_conv_write: assert property (@(posedge clk) disable iff (!rst_b)
        (wrEn && audioReset_b && index == acps_pkg::ACPS_IDX_POWER)
        |=> {leftConverterPower, rightConverterPower} == $past(writedata[3:2]))
        else $error("converter power write not applied");

    chk_master_write: assert property (@(posedge clk) disable iff (!rst_b)
        (wrEn && audioReset_b && index == acps_pkg::ACPS_IDX_PRECH)
        |=> blockPower[0] == $past(writedata[0]))
        else $error("master power write not applied");

    chk_filter_write: assert property (@(posedge clk) disable iff (!rst_b)
        (wrEn && audioReset_b && index == acps_pkg::ACPS_IDX_RESET)
        |=> filterReset_b == $past(writedata[1]))
        else $error("filter reset write not applied");

    chk_pin_amp: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && !audioReset_b) |=> ampGainCode == 4'h0 && !leftConverterPower && !codecResetMask)
        else $error("audio reset pin left amplifier or converters set");

    chk_gain_mid: assert property (@(posedge clk) disable iff (!rst_b)
        (ampGainCode == 4'h8) |-> ampGainDb == -6'sh01)
        else $error("gain code eight is not -1 dB");

    chk_mode_write: assert property (@(posedge clk) disable iff (!rst_b)
        (wrEn && audioReset_b && index == acps_pkg::ACPS_IDX_AMP && writedata[6:5] == 2'b11)
        |=> ampModeError && !ampOn && !ampCapCharge)
        else $error("forbidden amplifier mode not parked");
endmodule // acps_top

// ===== dv/acps_host_model.sv
// Controller model: drives the codec register bus and the audio reset pin
module acps_host_model #(
    parameter int LONG_WAIT = 20,
    parameter int SHORT_WAIT = 4
) (
    input wire logic clk,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    output logic audioReset_b,
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [3:0] byteenable,
    output logic [31:0] writedata
);
    timeunit 1ns;
    timeprecision 1ns;
    int timeouts = 0;
    logic [31:0] lastRead;
    initial
    begin
        audioReset_b = 1'b0;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'h0;
        writedata = 32'h0;
        // Supplies are taken as settled after a few cycles
        repeat (SHORT_WAIT + 4) @(posedge clk);
        audioReset_b <= 1'b1;
    end
    // ==========================================================
    // Bus access
    // Waitrequest and read data are taken in the time step of the edge that samples them
    task automatic access(input logic isRead, input logic [5:0] idx, input logic [7:0] d,
        input logic be);
        int n;
        @(posedge clk);
        address <= {idx, 2'b00};
        read <= isRead;
        write <= ~isRead;
        byteenable <= {3'h0, be};
        writedata <= {24'h0, d};
        n = 0;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 100)
            timeouts++;
        lastRead = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // Released lines carry no stale value
        address <= ~address;
        writedata <= ~writedata;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        access(1'b0, idx, d, 1'b1);
    endtask
    task automatic rd(input logic [5:0] idx);
        access(1'b1, idx, 8'h00, 1'b1);
    endtask
    // Delays are shortened stand-ins for the millisecond waits
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pinReset();
        @(posedge clk);
        audioReset_b <= 1'b0;
        pause(3);
        audioReset_b <= 1'b1;
    endtask
    // ==========================================================
    // Sequences
    task automatic headsetCharge();
        wr(acps_pkg::ACPS_IDX_RESET, 8'h07);
        wr(acps_pkg::ACPS_IDX_PRECH, 8'hFF);
        wr(acps_pkg::ACPS_IDX_POWER, 8'h30);
    endtask
    task automatic headsetFinish();
        pause(LONG_WAIT);
        wr(acps_pkg::ACPS_IDX_AUX, 8'h0C);
        pause(SHORT_WAIT);
        wr(acps_pkg::ACPS_IDX_POWER, 8'h3C);
    endtask
    task automatic headsetOff();
        wr(acps_pkg::ACPS_IDX_POWER, 8'h30);
        wr(acps_pkg::ACPS_IDX_PRECH, 8'h00);
        pause(SHORT_WAIT);
        wr(acps_pkg::ACPS_IDX_POWER, 8'h00);
    endtask
    task automatic i2sStart();
        wr(acps_pkg::ACPS_IDX_RESET, 8'h04);
        wr(acps_pkg::ACPS_IDX_RESET, 8'h04);
        wr(acps_pkg::ACPS_IDX_RESET, 8'h07);
        wr(acps_pkg::ACPS_IDX_RESET, 8'h03);
        pause(SHORT_WAIT);
        rd(acps_pkg::ACPS_IDX_POWER);
        wr(acps_pkg::ACPS_IDX_POWER, lastRead[7:0] | 8'h0C);
    endtask
    task automatic i2sStop();
        rd(acps_pkg::ACPS_IDX_POWER);
        wr(acps_pkg::ACPS_IDX_POWER, lastRead[7:0] & 8'hF3);
    endtask
    task automatic ampStart(input logic [3:0] g);
        wr(acps_pkg::ACPS_IDX_AMP, {4'h2, g});
        pause(SHORT_WAIT);
        wr(acps_pkg::ACPS_IDX_AMP, {4'h4, g});
    endtask
    task automatic ampStop();
        wr(acps_pkg::ACPS_IDX_AMP, 8'h4F);
        wr(acps_pkg::ACPS_IDX_AMP, 8'h0F);
    endtask
endmodule // acps_host_model

// ===== dv/audio_codec_powerup_sequencer_tb.sv
// Self-checking bench for the codec power sequencer
module audio_codec_powerup_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [5:0] PWR = acps_pkg::ACPS_IDX_POWER;
    localparam logic [5:0] PRE = acps_pkg::ACPS_IDX_PRECH;
    localparam logic [5:0] RST = acps_pkg::ACPS_IDX_RESET;
    localparam logic [5:0] AMP = acps_pkg::ACPS_IDX_AMP;
    logic clk, rst_b, ce, audioReset_b, read, write, waitrequest;
    logic leftConverterPower, rightConverterPower, codecReset_b, filterReset_b;
    logic codecResetMask, ampOn, ampCapCharge, ampPowerLevel, ampModeError;
    logic [7:0] address;
    logic [3:0] byteenable, ampGainCode;
    logic [31:0] writedata, readdata;
    logic [6:0] blockPower, blockCharging, blockReady;
    logic signed [5:0] ampGainDb;
    int n_mismatch, compares;
    acps_top #(.N(7)) u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .audioReset_b(audioReset_b),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .blockPower(blockPower), .blockCharging(blockCharging), .blockReady(blockReady),
        .leftConverterPower(leftConverterPower), .rightConverterPower(rightConverterPower),
        .codecReset_b(codecReset_b), .filterReset_b(filterReset_b),
        .codecResetMask(codecResetMask), .ampOn(ampOn), .ampCapCharge(ampCapCharge),
        .ampPowerLevel(ampPowerLevel), .ampGainCode(ampGainCode), .ampGainDb(ampGainDb),
        .ampModeError(ampModeError));
    acps_host_model #(.LONG_WAIT(20), .SHORT_WAIT(4)) u_host (.clk(clk),
        .readdata(readdata), .waitrequest(waitrequest), .audioReset_b(audioReset_b),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ==========================================================
    // Helpers
    task automatic finish_test();
        n_mismatch += u_host.timeouts;
        $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Two falling edges: registers land, then the trackers follow a cycle later
    task automatic settle();
        repeat (2) @(negedge clk);
        if (u_host.timeouts != 0)
        begin
            n_mismatch++;
            finish_test();
        end
    endtask
    task automatic w(input logic [5:0] idx, input logic [7:0] d);
        u_host.wr(idx, d);
        settle();
    endtask
    task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
        u_host.rd(idx);
        check(u_host.lastRead, exp);
    endtask
    function automatic logic [31:0] gainDb(input int c);
        int db;
        db = (c == 0) ? -22 : 20 - 3 * (c - 1);
        return {26'h0, 6'(db)};
    endfunction
    // ==========================================================
    // Scenarios
    task automatic test_reset();
        check({codecReset_b, filterReset_b, codecResetMask}, 3'b000);
        check($unsigned(ampGainDb), 32'h2A);
        rchk(AMP, 32'h0);
        rchk(6'h02, 32'h0);
        $display("test reset done");
    endtask
    task automatic test_headset();
        u_host.headsetCharge();
        settle();
        check({codecReset_b, filterReset_b, codecResetMask}, 3'b111);
        check(blockCharging, 7'h19);
        w(PWR, 8'hF3);
        check(blockCharging, 7'h7F);
        rchk(acps_pkg::ACPS_IDX_CHARGING, 32'h7F);
        u_host.headsetFinish();
        settle();
        check({leftConverterPower, rightConverterPower, blockPower}, 9'h199);
        check(blockCharging, 7'h19);
        w(PRE, 8'h01);
        check({blockCharging, blockReady}, 14'h0019);
        rchk(acps_pkg::ACPS_IDX_READY, 32'h19);
        $display("test headset done");
    endtask
    task automatic test_off();
        w(PRE, 8'h03);
        check(blockReady, 7'h19);
        u_host.headsetOff();
        settle();
        check({leftConverterPower, blockPower, blockReady}, 15'h0);
        w(PRE, 8'h03);
        check(blockCharging, 7'h01);
        w(PWR, 8'h01);
        w(PRE, 8'h01);
        check({blockCharging, blockReady}, 14'h0003);
        $display("test off done");
    endtask
    task automatic test_i2s();
        w(RST, 8'h04);
        check({codecReset_b, filterReset_b, codecResetMask}, 3'b001);
        u_host.i2sStart();
        settle();
        check({codecReset_b, filterReset_b, codecResetMask}, 3'b110);
        check({leftConverterPower, rightConverterPower}, 2'b11);
        u_host.i2sStop();
        settle();
        check({leftConverterPower, rightConverterPower, blockReady}, 9'h003);
        $display("test i2s done");
    endtask
    task automatic test_amp();
        for (int c = 0; c < 16; c++)
        begin
            w(AMP, 8'h10 | 8'(c));
            check({ampPowerLevel, ampGainCode}, {1'b1, c[3:0]});
            check($unsigned(ampGainDb), gainDb(c));
        end
        for (int m = 0; m < 4; m++)
        begin
            w(AMP, {1'b0, m[1:0], 5'h00});
            check({ampOn, ampCapCharge, ampModeError, ampPowerLevel},
                {m == 2, m == 1, m == 3, 1'b0});
        end
        w(AMP, 8'hFF);
        rchk(AMP, 32'h7F);
        u_host.ampStart(4'h5);
        settle();
        check({ampOn, ampCapCharge}, 2'b10);
        u_host.ampStop();
        settle();
        check({ampOn, ampGainCode, ampGainDb}, 11'h3EA);
        $display("test amp done");
    endtask
    task automatic test_bus();
        u_host.access(1'b0, AMP, 8'h33, 1'b0);
        rchk(AMP, 32'h0F);
        w(6'h02, 8'h55);
        rchk(6'h02, 32'h0);
        w(acps_pkg::ACPS_IDX_READY, 8'hFF);
        rchk(acps_pkg::ACPS_IDX_READY, 32'h03);
        @(posedge clk);
        ce <= 1'b0;
        u_host.pinReset();
        settle();
        check(blockPower, 7'h03);
        @(posedge clk);
        ce <= 1'b1;
        u_host.pinReset();
        settle();
        rchk(AMP, 32'h0);
        check({codecReset_b, blockPower}, 8'h00);
        $display("test bus done");
    endtask
    initial
    begin
        rst_b = 1'b0;
        ce = 1'b1;
        n_mismatch = 0;
        compares = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (12) @(posedge clk);
        test_reset();
        test_headset();
        test_off();
        test_i2s();
        test_amp();
        test_bus();
        finish_test();
    end
endmodule // audio_codec_powerup_sequencer_tb
